// ### hw/display_refresh_pkg.sv
// Shared constants and carrier types for the display refresh pixel path
package display_refresh_pkg;

    // ------------------------------------------------------------------
    // Register offsets (APB byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] DISPLAY_MODE_OFFSET   = 12'h010;
    localparam logic [11:0] START_ADDRESS_OFFSET  = 12'h040;
    localparam logic [11:0] LINE_STRIDE_OFFSET    = 12'h044;
    localparam logic [11:0] PANEL_SIZE_OFFSET     = 12'h048;
    localparam logic [11:0] REFRESH_STATUS_OFFSET = 12'h04C;
    localparam logic [11:0] LUT_BASE_OFFSET       = 12'h400;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_BPP_LSB      = 0;
    localparam int MODE_INVERT_BIT   = 4;
    localparam int MODE_COLOUR_BIT   = 5;
    localparam int MODE_DOUBLE_BIT   = 6;
    localparam int MODE_ENABLE_BIT   = 7;
    localparam int MODE_ROTATION_LSB = 16;
    localparam int PANEL_HEIGHT_LSB  = 16;
    localparam int LUT_RED_LSB       = 16;
    localparam int LUT_GREEN_LSB     = 8;
    localparam int LUT_BLUE_LSB      = 0;
    localparam int STATUS_BUSY_BIT   = 0;
    localparam int STATUS_WORD_LSB   = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] DISPLAY_MODE_RESET  = 32'h0000_0000;
    localparam logic [16:0] START_ADDRESS_RESET = 17'h0_0000;
    localparam logic [9:0]  LINE_STRIDE_RESET   = 10'h000;
    localparam logic [9:0]  PANEL_DIM_RESET     = 10'h000;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ROTATE_NONE = 2'h0,
        ROTATE_90   = 2'h1,
        ROTATE_180  = 2'h2,
        ROTATE_270  = 2'h3
    } rotation_type;

    localparam logic [2:0] BPP_SEL_16 = 3'h4;

    typedef struct packed {
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
    } pixel_type;

endpackage : display_refresh_pkg

// ### hw/display_refresh_rotation_lut.sv
// Display refresh pixel path: buffer fetch, rotation scan, colour look-up table, inversion
`timescale 1ns/1ps

module display_refresh_rotation_lut #(
    parameter int LUT_DEPTH = 256
) (
    input  wire logic                           clk_sys,
    input  wire logic                           reset_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [11:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           host_req,
    input  wire logic                           host_we,
    input  wire logic [16:0]                    host_addr,
    input  wire logic [31:0]                    host_wdata,
    output logic                                host_ack,
    output logic      [31:0]                    host_rdata,
    output logic                                buf_req,
    output logic                                buf_we,
    output logic      [16:0]                    buf_addr,
    output logic      [31:0]                    buf_wdata,
    input  wire logic                           buf_ack,
    input  wire logic [31:0]                    buf_rdata,
    output logic                                pix_valid,
    output display_refresh_pkg::pixel_type      pix_data,
    input  wire logic                           pix_ready
);

    // ------------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------------
    logic [31:0]                    mode_r;
    logic [16:0]                    start_word_r;
    logic [9:0]                     stride_r;
    logic [9:0]                     panel_width_r;
    logic [9:0]                     panel_height_r;
    logic [5:0]                     lut_red_r   [LUT_DEPTH];
    logic [5:0]                     lut_green_r [LUT_DEPTH];
    logic [5:0]                     lut_blue_r  [LUT_DEPTH];
    logic [31:0]                    prdata_r;
    logic                           pready_r;
    logic                           pslverr_r;
    logic                           apb_take;
    logic                           lut_hit;
    logic [7:0]                     lut_sel;
    logic                           busy;
    logic [31:0]                    read_value;
    logic                           read_ok;

    display_refresh_pkg::rotation_type rotation;
    logic [2:0]                     bpp_sel;
    logic                           colour_mode;
    logic                           invert_on;
    logic                           double_on;

    assign rotation    = display_refresh_pkg::rotation_type'(mode_r[display_refresh_pkg::MODE_ROTATION_LSB +: 2]);
    assign bpp_sel     = mode_r[display_refresh_pkg::MODE_BPP_LSB +: 3];
    assign colour_mode = mode_r[display_refresh_pkg::MODE_COLOUR_BIT];
    assign invert_on   = mode_r[display_refresh_pkg::MODE_INVERT_BIT];
    // Doubling cannot work on a column scan, so it is forced off there
    assign double_on   = mode_r[display_refresh_pkg::MODE_DOUBLE_BIT] & ~rotation[0];

    // Access phase lasts two cycles: pready rises one edge after penable
    assign apb_take = psel & penable & pready_r;
    assign lut_hit  = (paddr[11:10] == display_refresh_pkg::LUT_BASE_OFFSET[11:10]) && (paddr[1:0] == 2'h0);
    assign lut_sel  = paddr[9:2];

    always_comb begin
        read_value = 32'h0000_0000;
        read_ok    = 1'b1;
        if (lut_hit) begin
            read_value[display_refresh_pkg::LUT_RED_LSB +: 6]   = lut_red_r[lut_sel];
            read_value[display_refresh_pkg::LUT_GREEN_LSB +: 6] = lut_green_r[lut_sel];
            read_value[display_refresh_pkg::LUT_BLUE_LSB +: 6]  = lut_blue_r[lut_sel];
        end else begin
            unique case (paddr)
                display_refresh_pkg::DISPLAY_MODE_OFFSET:   read_value = mode_r;
                display_refresh_pkg::START_ADDRESS_OFFSET:  read_value[16:0] = start_word_r;
                display_refresh_pkg::LINE_STRIDE_OFFSET:    read_value[9:0] = stride_r;
                display_refresh_pkg::PANEL_SIZE_OFFSET: begin
                    read_value[9:0] = panel_width_r;
                    read_value[display_refresh_pkg::PANEL_HEIGHT_LSB +: 10] = panel_height_r;
                end
                display_refresh_pkg::REFRESH_STATUS_OFFSET: begin
                    read_value[display_refresh_pkg::STATUS_BUSY_BIT] = busy;
                    read_value[display_refresh_pkg::STATUS_WORD_LSB +: 17] = buf_addr;
                end
                default: read_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~read_ok;
            prdata_r  <= (psel & penable & ~pready_r & ~pwrite & read_ok) ? read_value : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_r         <= display_refresh_pkg::DISPLAY_MODE_RESET;
            start_word_r   <= display_refresh_pkg::START_ADDRESS_RESET;
            stride_r       <= display_refresh_pkg::LINE_STRIDE_RESET;
            panel_width_r  <= display_refresh_pkg::PANEL_DIM_RESET;
            panel_height_r <= display_refresh_pkg::PANEL_DIM_RESET;
        end else if (apb_take && pwrite && !lut_hit) begin
            unique case (paddr)
                display_refresh_pkg::DISPLAY_MODE_OFFSET:  mode_r <= pwdata;
                display_refresh_pkg::START_ADDRESS_OFFSET: start_word_r <= pwdata[16:0];
                display_refresh_pkg::LINE_STRIDE_OFFSET:   stride_r <= pwdata[9:0];
                display_refresh_pkg::PANEL_SIZE_OFFSET: begin
                    panel_width_r  <= pwdata[9:0];
                    panel_height_r <= pwdata[display_refresh_pkg::PANEL_HEIGHT_LSB +: 10];
                end
                default: ;
            endcase
        end
    end

    // Table is plain flip-flops, no reset: software loads it before enabling refresh
    always_ff @(posedge clk_sys) begin
        if (apb_take && pwrite && lut_hit) begin
            lut_red_r[lut_sel]   <= pwdata[display_refresh_pkg::LUT_RED_LSB +: 6];
            lut_green_r[lut_sel] <= pwdata[display_refresh_pkg::LUT_GREEN_LSB +: 6];
            lut_blue_r[lut_sel]  <= pwdata[display_refresh_pkg::LUT_BLUE_LSB +: 6];
        end
    end

    // ------------------------------------------------------------------
    // Buffer port: host first, refresh fetch otherwise
    // ------------------------------------------------------------------
    typedef enum {ST_IDLE, ST_FETCH, ST_SHOW} refresh_state_type;
    refresh_state_type              state_r;
    logic                           owner_host_r;
    logic                           host_ack_r;
    logic [31:0]                    host_rdata_r;
    logic                           buf_req_r;
    logic                           buf_we_r;
    logic [16:0]                    buf_addr_r;
    logic [31:0]                    buf_wdata_r;
    logic [21:0]                    pos_r;
    logic [21:0]                    line_pos_r;
    logic                           fetch_done;

    assign fetch_done = buf_req_r & buf_ack & ~owner_host_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            buf_req_r    <= 1'b0;
            buf_we_r     <= 1'b0;
            buf_addr_r   <= 17'h0_0000;
            buf_wdata_r  <= 32'h0000_0000;
            owner_host_r <= 1'b0;
            host_ack_r   <= 1'b0;
            host_rdata_r <= 32'h0000_0000;
        end else begin
            host_ack_r <= 1'b0;
            if (!buf_req_r) begin
                if (host_req && !host_ack_r) begin
                    buf_req_r    <= 1'b1;
                    owner_host_r <= 1'b1;
                    buf_we_r     <= host_we;
                    buf_addr_r   <= host_addr;
                    buf_wdata_r  <= host_wdata;
                end else if (state_r == ST_FETCH) begin
                    buf_req_r    <= 1'b1;
                    owner_host_r <= 1'b0;
                    buf_we_r     <= 1'b0;
                    buf_addr_r   <= pos_r[21:5];
                end
            end else if (buf_ack) begin
                buf_req_r <= 1'b0;
                if (owner_host_r) begin
                    host_ack_r   <= 1'b1;
                    host_rdata_r <= buf_rdata;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pixel extraction and colour mapping
    // ------------------------------------------------------------------
    logic [4:0]                     bpp_bits;
    logic [7:0]                     fetch_byte;
    logic [15:0]                    fetch_half;
    logic [7:0]                     pixel_index;
    logic [3:0]                     shift_amt;
    logic [7:0]                     index_mask;
    display_refresh_pkg::pixel_type mapped;

    assign bpp_bits = 5'(5'h01 << bpp_sel);

    always_comb begin
        // Little-endian lanes; within a byte the earliest pixel sits in the upper bits
        fetch_byte  = buf_rdata[{pos_r[4:3], 3'h0} +: 8];
        fetch_half  = pos_r[4] ? buf_rdata[31:16] : buf_rdata[15:0];
        shift_amt   = 4'(4'h8 - 4'(bpp_bits) - {1'b0, pos_r[2:0]});
        index_mask  = 8'(9'h0FF >> (4'h8 - 4'(bpp_bits)));
        pixel_index = (fetch_byte >> shift_amt) & index_mask;
        mapped      = '0;
        if (bpp_sel == display_refresh_pkg::BPP_SEL_16) begin
            if (colour_mode) begin
                mapped.red   = {fetch_half[15:11], 1'b0};
                mapped.green = fetch_half[10:5];
                mapped.blue  = {fetch_half[4:0], 1'b0};
            end else begin
                mapped.red   = fetch_half[10:5];
                mapped.green = fetch_half[10:5];
                mapped.blue  = fetch_half[10:5];
            end
        end else if (colour_mode) begin
            mapped.red   = lut_red_r[pixel_index];
            mapped.green = lut_green_r[pixel_index];
            mapped.blue  = lut_blue_r[pixel_index];
        end else begin
            mapped.red   = lut_green_r[pixel_index];
            mapped.green = lut_green_r[pixel_index];
            mapped.blue  = lut_green_r[pixel_index];
        end
        if (invert_on) begin
            mapped = ~mapped;
        end
    end

    // ------------------------------------------------------------------
    // Rotated scan: step along a panel line and between panel lines
    // ------------------------------------------------------------------
    logic [21:0]                    stride_bits;
    logic [21:0]                    pixel_step;
    logic [21:0]                    along_step;
    logic [21:0]                    line_step;
    logic [21:0]                    first_pos;
    logic [9:0]                     col_r;
    logic [9:0]                     row_r;
    logic                           repeat_r;
    logic                           pix_valid_r;
    display_refresh_pkg::pixel_type pix_data_r;
    logic                           last_col;
    logic                           last_row;

    assign stride_bits = {7'h00, stride_r, 5'h00};
    assign pixel_step  = {17'h0_0000, bpp_bits};
    assign last_col    = (col_r == 10'(panel_width_r - 10'h001));
    assign last_row    = (row_r == 10'(panel_height_r - 10'h001));
    assign busy        = (state_r != ST_IDLE);

    always_comb begin
        unique case (rotation)
            display_refresh_pkg::ROTATE_NONE: begin
                along_step = pixel_step;
                line_step  = stride_bits;
                first_pos  = {start_word_r, 5'h00};
            end
            display_refresh_pkg::ROTATE_90: begin
                along_step = stride_bits;
                line_step  = 22'(-pixel_step);
                first_pos  = 22'({start_word_r, 5'h00} + 22'h20 - pixel_step);
            end
            display_refresh_pkg::ROTATE_180: begin
                along_step = 22'(-pixel_step);
                line_step  = 22'(-stride_bits);
                first_pos  = 22'({start_word_r, 5'h00} + 22'h20 - pixel_step);
            end
            display_refresh_pkg::ROTATE_270: begin
                along_step = 22'(-stride_bits);
                line_step  = pixel_step;
                first_pos  = {start_word_r, 5'h00};
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= ST_IDLE;
            pos_r       <= 22'h00_0000;
            line_pos_r  <= 22'h00_0000;
            col_r       <= 10'h000;
            row_r       <= 10'h000;
            repeat_r    <= 1'b0;
            pix_valid_r <= 1'b0;
            pix_data_r  <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (mode_r[display_refresh_pkg::MODE_ENABLE_BIT]) begin
                        state_r    <= ST_FETCH;
                        pos_r      <= first_pos;
                        line_pos_r <= first_pos;
                        col_r      <= 10'h000;
                        row_r      <= 10'h000;
                        repeat_r   <= 1'b0;
                    end
                end
                ST_FETCH: begin
                    if (fetch_done) begin
                        state_r     <= ST_SHOW;
                        pix_valid_r <= 1'b1;
                        pix_data_r  <= mapped;
                    end
                end
                ST_SHOW: begin
                    if (pix_ready) begin
                        if (double_on && !repeat_r) begin
                            repeat_r <= 1'b1;
                        end else begin
                            repeat_r    <= 1'b0;
                            pix_valid_r <= 1'b0;
                            if (!last_col) begin
                                col_r   <= 10'(col_r + 10'h001);
                                pos_r   <= 22'(pos_r + along_step);
                                state_r <= ST_FETCH;
                            end else if (!last_row) begin
                                col_r      <= 10'h000;
                                row_r      <= 10'(row_r + 10'h001);
                                pos_r      <= 22'(line_pos_r + line_step);
                                line_pos_r <= 22'(line_pos_r + line_step);
                                state_r    <= ST_FETCH;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign host_ack   = host_ack_r;
    assign host_rdata = host_rdata_r;
    assign buf_req    = buf_req_r;
    assign buf_we     = buf_we_r;
    assign buf_addr   = buf_addr_r;
    assign buf_wdata  = buf_wdata_r;
    assign pix_valid  = pix_valid_r;
    assign pix_data   = pix_data_r;

endmodule : display_refresh_rotation_lut

// ### verification/display_refresh_rotation_lut_asserts.sv
// Port assertions for the display refresh pixel path
`timescale 1ns/1ps
module display_refresh_rotation_lut_asserts (
    input wire logic                           clk_sys, reset_n, psel, penable, pready, pslverr,
    input wire logic [31:0]                    prdata,
    input wire logic                           host_ack, buf_req, buf_we, buf_ack, pix_valid, pix_ready,
    input wire logic [16:0]                    buf_addr,
    input wire display_refresh_pkg::pixel_type pix_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_access; $rose(penable) && psel; endsequence
    sequence s_stall; pix_valid && !pix_ready; endsequence
    a_apb_one_wait: assert property (s_access |-> !pready ##1 pready) else $error("pready timing");
    a_ready_single: assert property (pready |=> !pready) else $error("pready long");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    a_ack_after_mem: assert property (host_ack |-> $past(buf_ack) && !buf_req) else $error("ack cause");
    a_ack_pulse: assert property (host_ack |=> !host_ack) else $error("ack long");
    a_fetch_hold: assert property (buf_req && !buf_ack |=> buf_req && $stable(buf_addr) && $stable(buf_we))
        else $error("fetch moved");
    a_pix_hold: assert property (s_stall |=> pix_valid && $stable(pix_data)) else $error("pixel moved");
    a_pix_after_fetch: assert property ($rose(pix_valid) |-> $past(buf_ack)) else $error("pixel cause");
endmodule : display_refresh_rotation_lut_asserts

bind display_refresh_rotation_lut display_refresh_rotation_lut_asserts chk (.clk_sys, .reset_n, .psel,
    .penable, .pready, .pslverr, .prdata, .host_ack, .buf_req, .buf_we, .buf_ack, .pix_valid, .pix_ready,
    .buf_addr, .pix_data);

// ### verification/panel_memory_model.sv
// Buffer memory and panel sink facing the refresh path
`timescale 1ns/1ps
module panel_memory_model (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        buf_req,
    input  wire logic        buf_we,
    input  wire logic [16:0] buf_addr,
    input  wire logic [31:0] buf_wdata,
    output logic             buf_ack,
    output logic      [31:0] buf_rdata,
    output logic             pix_ready
);
    logic [31:0] mem [0:63];
    int          seed = 32'hE747;
    // Random stalls; data bus inverts its last word every cycle outside an ack
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            buf_ack <= 1'b0;
            buf_rdata <= 32'h0;
            pix_ready <= 1'b0;
        end else begin
            pix_ready <= ($random(seed) & 1) != 0;
            if (buf_req && !buf_ack && ($random(seed) & 1) != 0) begin
                buf_ack <= 1'b1;
                buf_rdata <= mem[buf_addr[5:0]];
                if (buf_we) mem[buf_addr[5:0]] <= buf_wdata;
            end else begin
                buf_ack <= 1'b0;
                buf_rdata <= ~buf_rdata;
            end
        end
    end
endmodule : panel_memory_model

// ### verification/display_refresh_rotation_lut_tb.sv
// Self-checking bench: registers, host buffer path and refreshed pixel order
`timescale 1ns/1ps
module display_refresh_rotation_lut_tb;
    logic        clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic        host_req = 1'b0, host_we = 1'b0, pready, pslverr, host_ack, buf_req, buf_we, buf_ack;
    logic        pix_valid, pix_ready;
    logic [11:0] paddr = 12'h000;
    logic [16:0] host_addr = 17'h0_0000, buf_addr;
    logic [31:0] pwdata = 32'h0, host_wdata = 32'h0, prdata, host_rdata, buf_wdata, buf_rdata, r, img [2];
    logic [5:0]  lut_g [256];
    logic [17:0] exp_q [$];
    int          bad_count = 0, compares = 0, idx = 0, seed = 32'hE747, v, p;
    int          bsel [7] = '{3, 3, 4, 4, 0, 1, 2}, bpw [7] = '{8, 8, 16, 16, 1, 2, 4};
    int          wid [7] = '{4, 4, 2, 2, 32, 16, 8}, rot [7] = '{0, 2, 1, 0, 3, 0, 2};
    int          inv [7] = '{0, 1, 0, 1, 0, 0, 1}, col [7] = '{0, 0, 1, 0, 0, 0, 0};
    display_refresh_pkg::pixel_type pix_data;

    display_refresh_rotation_lut uut (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .host_req, .host_we, .host_addr, .host_wdata, .host_ack, .host_rdata, .buf_req,
        .buf_we, .buf_addr, .buf_wdata, .buf_ack, .buf_rdata, .pix_valid, .pix_data, .pix_ready);
    panel_memory_model far_end (.clk_sys, .reset_n, .buf_req, .buf_we, .buf_addr, .buf_wdata, .buf_ack,
        .buf_rdata, .pix_ready);

    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50) begin n++; @(posedge clk_sys); end
        if (pready !== 1'b1) bad_count++;
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic host(input logic w, input logic [16:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        host_req <= 1'b1; host_we <= w; host_addr <= a; host_wdata <= d;
        @(posedge clk_sys);
        while (host_ack !== 1'b1 && n < 50) begin n++; @(posedge clk_sys); end
        if (host_ack !== 1'b1) bad_count++;
        host_req <= 1'b0;
    endtask : host

    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Earliest pixel sits in the byte's high bits; 16 bpp takes the low halfword first
    function automatic logic [17:0] px(input int b, input int q, input int c, input int i);
        logic [31:0] w;
        logic [5:0]  g;
        logic [17:0] o;
        w = img[q / 32] >> (b == 16 ? q % 32 : q % 32 / 8 * 8);
        g = b == 16 ? w[10:5] : lut_g[8'((w[7:0] >> (8 - b - q % 8)) & ((1 << b) - 1))];
        o = (b == 16 && c != 0) ? {w[15:11], 1'b0, g, w[4:0], 1'b0} : {g, g, g};
        return i != 0 ? ~o : o;
    endfunction : px

    always @(posedge clk_sys)
        if (pix_valid === 1'b1 && pix_ready === 1'b1 && exp_q.size() > 0) begin
            chk({14'h0, pix_data}, {14'h0, exp_q[idx % exp_q.size()]});
            idx++;
        end

    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b0, display_refresh_pkg::START_ADDRESS_OFFSET, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, display_refresh_pkg::START_ADDRESS_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, display_refresh_pkg::START_ADDRESS_OFFSET, 32'h0);
        chk(r, 32'h0001_FFFF);
        apb(1'b1, display_refresh_pkg::LINE_STRIDE_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, display_refresh_pkg::LINE_STRIDE_OFFSET, 32'h0);
        chk(r, 32'h0000_03FF);
        apb(1'b1, 12'h0FC, 32'h1234_5678);
        chk({r[30:0], e}, 32'h1);
        for (int q = 0; q < 4; q++) begin
            apb(1'b1, display_refresh_pkg::DISPLAY_MODE_OFFSET, q << 16);
            apb(1'b0, display_refresh_pkg::DISPLAY_MODE_OFFSET, 32'h0);
            chk(r, q << 16);
        end
        for (int i = 0; i < 256; i++) begin
            v = $random(seed);
            lut_g[i] = v[13:8];
            apb(1'b1, display_refresh_pkg::LUT_BASE_OFFSET + 12'(4 * i), v);
        end
        for (int k = 0; k < 7; k++) begin
            for (int j = 0; j < 2; j++) begin
                img[j] = $random(seed);
                host(1'b1, 17'(j), img[j]);
                host(1'b0, 17'(j), 32'h0);
                chk(host_rdata, img[j]);
            end
            exp_q.delete();
            for (p = 0; p < 2 * wid[k]; p++) begin
                v = p;
                if (rot[k] == 1) v = p % 2 * wid[k] + wid[k] - 1 - p / 2;
                if (rot[k] == 3) v = (1 - p % 2) * wid[k] + p / 2;
                exp_q.push_back(px(bpw[k], v * bpw[k], col[k], inv[k]));
            end
            if (rot[k] == 2) exp_q.reverse();
            v = 0;
            if (rot[k] == 1) v = wid[k] * bpw[k] / 32 - 1;
            if (rot[k] == 2) v = (wid[k] + wid[k]) * bpw[k] / 32 - 1;
            if (rot[k] == 3) v = wid[k] * bpw[k] / 32;
            apb(1'b1, display_refresh_pkg::START_ADDRESS_OFFSET, v);
            apb(1'b1, display_refresh_pkg::LINE_STRIDE_OFFSET, wid[k] * bpw[k] / 32);
            apb(1'b1, display_refresh_pkg::PANEL_SIZE_OFFSET, rot[k] % 2 ? wid[k] << 16 | 2 : 32'h0002_0000 | wid[k]);
            idx = 0;
            // Doubling requested in 90/270 must be ignored
            v = bsel[k] | inv[k] << 4 | col[k] << 5 | rot[k] % 2 << 6 | rot[k] << 16;
            apb(1'b1, display_refresh_pkg::DISPLAY_MODE_OFFSET, v | 128);
            for (int n = 0; n < 5000 && idx < 2 * exp_q.size(); n++) @(posedge clk_sys);
            // Only enable drops: the frame in flight still runs with these settings
            apb(1'b1, display_refresh_pkg::DISPLAY_MODE_OFFSET, v);
            r = 32'h1;
            for (int n = 0; n < 500 && r[0] !== 1'b0; n++) apb(1'b0, display_refresh_pkg::REFRESH_STATUS_OFFSET, 32'h0);
            chk(32'(idx >= 2 * exp_q.size() && r[0] === 1'b0), 32'h1);
            exp_q.delete();
        end
        wrap_up();
    end
endmodule : display_refresh_rotation_lut_tb
